// *** zd_status_cfg.svh ***
// register offsets, field positions and reset values of the zero-delay and status bank
`ifndef ZD_STATUS_CFG_SVH
`define ZD_STATUS_CFG_SVH
`define ZD_CTRL_ADDR      10'h01E
`define ZD_STATUS_ADDR    10'h01F
`define ZD_DIV_SEL_LSB    3
`define ZD_EXT_MODE_BIT   2
`define ZD_ENABLE_BIT     1
`define ZD_CTRL_RESET     8'h00
`define ZD_STATUS_RESET   8'h00
`define ZD_CTRL_MASK      8'h1E
`define ZD_DIV_SEL_WIDTH  2
`define ZD_ST_RSVD_BIT    7
`define ZD_ST_CAL_BIT     6
`define ZD_ST_HOLD_BIT    5
`define ZD_ST_SEL_BIT     4
`define ZD_ST_VCO_BIT     3
`define ZD_ST_SEC_BIT     2
`define ZD_ST_FIRST_BIT   1
`define ZD_ST_LOCK_BIT    0
`endif

// *** zd_status_pkg.sv ***
// types shared by the zero-delay and pll status register bank
package zd_status_pkg;
    typedef enum logic [1:0] {
        zd_off,
        zd_internal,
        zd_external
    } zd_mode_t;

    typedef struct packed {
        logic       cal_done;
        logic       holdover_active;
        logic       second_ref_selected;
        logic       vco_above;
        logic       second_ref_above;
        logic       first_ref_above;
        logic       locked;
    } pll_status_t;

    typedef struct packed {
        logic [9:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_t;
endpackage

// *** zd_status_snapshot.sv ***
// holds the status readback image, refreshed unless readback updates are disabled
`timescale 1ns/1ps
`default_nettype none
module zd_status_snapshot (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         reset,
    // live status and refresh control
    input  wire zd_status_pkg::pll_status_t   live,
    input  wire logic                         freeze,
    // held image
    output var  zd_status_pkg::pll_status_t   held
);
    typedef struct packed {
        zd_status_pkg::pll_status_t img;
    } snap_state_t;

    snap_state_t state;
    snap_state_t next_state;

    always_comb begin
        next_state = state;
        if (!freeze) begin
            next_state.img = live;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign held = state.img;
endmodule // zd_status_snapshot
`default_nettype wire

// *** zd_status_regs.sv ***
// zero-delay control register and pll status readback register
`timescale 1ns/1ps
`default_nettype none
`include "zd_status_cfg.svh"
module zd_status_regs (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         reset,
    // register access from the serial control port
    input  wire zd_status_pkg::reg_req_t      req,
    output var  logic [7:0]                   rdata,
    output var  logic                         rvalid,
    // readback disable bit from the preceding control register
    input  wire logic                         status_readback_disable,
    // live pll conditions
    input  wire logic                         vco_cal_done,
    input  wire logic                         holdover_active,
    input  wire logic                         second_reference_input_selected,
    input  wire logic                         vco_above_threshold,
    input  wire logic                         second_reference_input_above,
    input  wire logic                         first_reference_input_above,
    input  wire logic                         digital_lock,
    // zero-delay controls
    output var  logic [1:0]                   zd_feedback_div_sel,
    output var  logic                         zd_enable,
    output var  logic                         zd_external_mode,
    output var  zd_status_pkg::zd_mode_t      zd_mode
);
    typedef struct packed {
        logic [7:0]              ctrl;
        logic [7:0]              rdata;
        logic                    rvalid;
        zd_status_pkg::zd_mode_t mode;
    } regs_state_t;

    regs_state_t                state;
    regs_state_t                next_state;
    zd_status_pkg::pll_status_t live;
    zd_status_pkg::pll_status_t held;

    typedef struct packed {
        logic ctrl_wr;
        logic status_wr;
        logic ctrl_rd;
        logic status_rd;
        logic other_rd;
    } access_t;

    access_t                    access;
    logic [7:0]                 ctrl_image;
    logic [7:0]                 status_image;
    logic [7:0]                 next_rdata;

    // address decode, shared by the write and read paths
    function automatic logic is_ctrl_addr(input logic [9:0] a);
        is_ctrl_addr = (a == `ZD_CTRL_ADDR);
    endfunction

    function automatic logic is_status_addr(input logic [9:0] a);
        is_status_addr = (a == `ZD_STATUS_ADDR);
    endfunction

    // only divider select, mode and enable bits are writable
    function automatic logic [7:0] ctrl_masked(input logic [7:0] d);
        ctrl_masked = d & `ZD_CTRL_MASK;
    endfunction

    // field extraction from a control byte
    function automatic logic [1:0] div_sel_of(input logic [7:0] c);
        div_sel_of = c[`ZD_DIV_SEL_LSB +: `ZD_DIV_SEL_WIDTH];
    endfunction

    function automatic logic enable_of(input logic [7:0] c);
        enable_of = c[`ZD_ENABLE_BIT];
    endfunction

    function automatic logic ext_mode_of(input logic [7:0] c);
        ext_mode_of = c[`ZD_EXT_MODE_BIT];
    endfunction

    // places each status condition at its readback position
    function automatic logic [7:0] status_byte(input zd_status_pkg::pll_status_t s);
        status_byte                    = 8'h00;
        status_byte[`ZD_ST_CAL_BIT]    = s.cal_done;
        status_byte[`ZD_ST_HOLD_BIT]   = s.holdover_active;
        status_byte[`ZD_ST_SEL_BIT]    = s.second_ref_selected;
        status_byte[`ZD_ST_VCO_BIT]    = s.vco_above;
        status_byte[`ZD_ST_SEC_BIT]    = s.second_ref_above;
        status_byte[`ZD_ST_FIRST_BIT]  = s.first_ref_above;
        status_byte[`ZD_ST_LOCK_BIT]   = s.locked;
        status_byte[`ZD_ST_RSVD_BIT]   = 1'b0;
    endfunction

    // read data selection for one decoded access
    function automatic logic [7:0] read_mux(input access_t acc_in, input logic [7:0] c, input logic [7:0] s);
        if (acc_in.ctrl_rd) begin
            read_mux = c;
        end else if (acc_in.status_rd) begin
            read_mux = s;
        end else begin
            read_mux = 8'h00;
        end
    endfunction

    function automatic zd_status_pkg::zd_mode_t mode_of(input logic [7:0] c);
        if (!enable_of(c)) begin
            mode_of = zd_status_pkg::zd_off;
        end else if (ext_mode_of(c)) begin
            mode_of = zd_status_pkg::zd_external;
        end else begin
            mode_of = zd_status_pkg::zd_internal;
        end
    endfunction

    always_comb begin
        live.cal_done            = vco_cal_done;
        live.holdover_active     = holdover_active;
        live.second_ref_selected = second_reference_input_selected;
        live.vco_above           = vco_above_threshold;
        live.second_ref_above    = second_reference_input_above;
        live.first_ref_above     = first_reference_input_above;
        live.locked              = digital_lock;
    end

    zd_status_snapshot u_snapshot (
        .clk    (clk),
        .reset  (reset),
        .live   (live),
        .freeze (status_readback_disable),
        .held   (held)
    );

    // decode the request once for both paths
    always_comb begin
        access           = '0;
        access.ctrl_wr   = req.wr && is_ctrl_addr(req.addr);
        access.status_wr = req.wr && is_status_addr(req.addr);
        access.ctrl_rd   = req.rd && is_ctrl_addr(req.addr);
        access.status_rd = req.rd && is_status_addr(req.addr);
        access.other_rd  = req.rd && !is_ctrl_addr(req.addr) && !is_status_addr(req.addr);
    end

    // readable images of both registers
    always_comb begin
        ctrl_image   = state.ctrl;
        status_image = status_byte(held);
        next_rdata   = read_mux(access, ctrl_image, status_image);
    end

    always_comb begin
        next_state        = state;
        next_state.rvalid = 1'b0;
        if (access.ctrl_wr) begin
            next_state.ctrl = ctrl_masked(req.wdata);
        end else if (access.status_wr) begin
            next_state.ctrl = state.ctrl; // status is read-only
        end
        if (req.rd) begin
            next_state.rvalid = 1'b1;
            next_state.rdata  = next_rdata; // reads see the value before a same-cycle write
        end
        next_state.mode = mode_of(next_state.ctrl);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state.ctrl   <= `ZD_CTRL_RESET;
            state.rdata  <= `ZD_STATUS_RESET;
            state.rvalid <= 1'b0;
            state.mode   <= zd_status_pkg::zd_off;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        rdata               = state.rdata;
        rvalid              = state.rvalid;
        zd_feedback_div_sel = div_sel_of(state.ctrl);
        zd_enable           = enable_of(state.ctrl);
        zd_external_mode    = ext_mode_of(state.ctrl);
        zd_mode             = state.mode;
    end
endmodule // zd_status_regs
`default_nettype wire

// *** zd_status_regs_assertions.sv ***
// assertions for the zero-delay and status register bank
`timescale 1ns/1ps
`default_nettype none
module zd_status_regs_assertions (
    input wire logic clk, reset, status_readback_disable, rvalid, zd_enable, zd_external_mode,
    input wire zd_status_pkg::reg_req_t req,
    input wire logic [7:0] rdata,
    input wire logic vco_cal_done, holdover_active, second_reference_input_selected, vco_above_threshold,
    input wire logic second_reference_input_above, first_reference_input_above, digital_lock,
    input wire logic [1:0] zd_feedback_div_sel,
    input wire zd_status_pkg::zd_mode_t zd_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic wr_c = req.wr && req.addr == 10'h01E;
    wire logic rd_s = req.rd && req.addr == 10'h01F;
    wire logic [6:0] live = {vco_cal_done, holdover_active, second_reference_input_selected,
        vco_above_threshold, second_reference_input_above, first_reference_input_above, digital_lock};
    sequence s_stat_rd; rd_s && !$past(status_readback_disable) && !$past(reset); endsequence
    sequence s_frozen_pair; rd_s && status_readback_disable ##1 rd_s; endsequence
    AST_DIV: assert property (wr_c |=> zd_feedback_div_sel == $past(req.wdata[4:3])) else $error("div");
    AST_EN: assert property (wr_c |=> zd_enable == $past(req.wdata[1])) else $error("enable");
    AST_EXT: assert property (wr_c |=> zd_external_mode == $past(req.wdata[2])) else $error("ext");
    AST_MODE: assert property (zd_mode == (!zd_enable ? zd_status_pkg::zd_off :
        zd_external_mode ? zd_status_pkg::zd_external : zd_status_pkg::zd_internal)) else $error("mode");
    AST_STAT: assert property (s_stat_rd |=> rdata == {1'h0, $past(live, 2)})
        else $error("status");
    AST_FRZ: assert property (s_frozen_pair |=> $stable(rdata)) else $error("freeze");
    AST_B7: assert property (rd_s |=> rvalid && !rdata[7]) else $error("bit7");
    AST_CRD: assert property (req.rd && !req.wr && req.addr == 10'h01E |=> rdata ==
        {3'h0, zd_feedback_div_sel, zd_external_mode, zd_enable, 1'h0}) else $error("ctrl read");
endmodule // zd_status_regs_assertions
`default_nettype wire

// *** tb.sv ***
// self-checking testbench for the zero-delay and status register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, reset = 1, status_readback_disable = 0, rvalid, zd_enable, zd_external_mode;
    logic vco_cal_done = 0, holdover_active = 0, second_reference_input_selected = 0;
    logic vco_above_threshold = 0, second_reference_input_above = 0;
    logic first_reference_input_above = 0, digital_lock = 0;
    zd_status_pkg::reg_req_t req = '0;
    logic [7:0] rdata;
    logic [1:0] zd_feedback_div_sel;
    zd_status_pkg::zd_mode_t zd_mode;
    int failures = 0, num_checks = 0;
    logic [15:0] rows [5] = '{16'h0606, 16'h0A0A, 16'h1212, 16'hFF1E, 16'h0404};
    zd_status_regs i_zd_status_regs (.*);
    initial forever #5 clk = ~clk;
    task tally_and_finish;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task acc(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(posedge clk) req <= '{a, w, !w, d};
        @(posedge clk) req <= '0;
        #1;
    endtask
    task rd(input logic [9:0] a, input logic [7:0] e);
        acc(1'h0, a, 8'h00);
        chk(rvalid, 8'h01);
        chk(rdata, e);
    endtask
    task live(input logic [6:0] v);
        @(posedge clk) {vco_cal_done, holdover_active, second_reference_input_selected, vco_above_threshold,
            second_reference_input_above, first_reference_input_above, digital_lock} <= v;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        reset <= 0;
        #1 chk({zd_feedback_div_sel, zd_enable, zd_external_mode, 2'(zd_mode)}, 8'h00);
        rd(10'h01E, 8'h00);
        rd(10'h01F, 8'h00);
        foreach (rows[i]) begin
            acc(1'h1, 10'h01E, rows[i][15:8]);
            chk({zd_feedback_div_sel, zd_external_mode, zd_enable}, rows[i][4:1]);
            chk(zd_mode, rows[i][1] ? (rows[i][2] ? 8'h02 : 8'h01) : 8'h00);
            rd(10'h01E, rows[i][7:0]);
        end
        live(7'h55);
        rd(10'h01F, 8'h55);
        live(7'h2A);
        rd(10'h01F, 8'h2A);
        @(posedge clk) status_readback_disable <= 1;
        live(7'h7F);
        acc(1'h1, 10'h01F, 8'hFF);
        @(posedge clk) req <= '{10'h01F, 1'h0, 1'h1, 8'h00};
        repeat (2) @(posedge clk);
        req <= '0;
        #1 chk(rdata, 8'h2A);
        @(posedge clk) status_readback_disable <= 0;
        rd(10'h01F, 8'h7F);
        rd(10'h020, 8'h00);
        @(posedge clk) #1 chk(rvalid, 8'h00);
        @(posedge clk) reset <= 1;
        @(posedge clk) reset <= 0;
        rd(10'h01E, 8'h00);
        tally_and_finish;
    end
    initial begin
        #20000;
        failures++;
        tally_and_finish;
    end
endmodule // tb
bind zd_status_regs zd_status_regs_assertions i_zd_status_regs_assertions (.*);
`default_nettype wire
